// ===== design/dsic_defines.svh
// Purpose: shared constants of the serial input and clear front end
// Assumes: included by bare name from package and top module
// Notes:   widths, counts, field positions, command codes, code levels, clock limit, reset values
`ifndef DSIC_DEFINES_SVH
`define DSIC_DEFINES_SVH

// serial word and converter code widths, channel count and buffer depth
`define DSIC_WORD_W        32
`define DSIC_CODE_W        16
`define DSIC_CHAN_N        8
`define DSIC_FIFO_DEPTH    16
// falling clock edges in one complete frame
`define DSIC_FRAME_BITS    6'h20
// highest serial clock rate the host may use, in MHz
`define DSIC_SCLK_MAX_MHZ  50
// command word field positions
`define DSIC_CMD_HI        27
`define DSIC_CMD_LO        24
`define DSIC_CHAN_HI       23
`define DSIC_CHAN_LO       20
`define DSIC_DATA_HI       19
`define DSIC_DATA_LO       4
// command codes
`define DSIC_CMD_WRITE     4'h0
`define DSIC_CMD_CLRCODE   4'h1
`define DSIC_CMD_REFSEL    4'h2
// clear code levels
`define DSIC_ZERO_CODE     16'h0000
`define DSIC_MID_CODE      16'h8000
`define DSIC_FULL_CODE     16'hFFFF
// reset values
`define DSIC_CLRSEL_RESET  2'h0
`define DSIC_CODE_RESET    16'h0000

`endif

// ===== design/dsic_fifo.sv
// Purpose: word buffer between serial receive and register update
// Assumes: single clock, synchronous active high reset
// Notes:   push when full is refused; in_ready_o shows room
`timescale 1ns/1ns
`default_nettype none

module dsic_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    input  wire logic         in_valid_i,
    output var  logic         in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output var  logic         out_valid_o,
    input  wire logic         out_ready_i,
    output var  logic [W-1:0] out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem_r [D];     // storage, flip-flops
    logic [AW-1:0] wr_r;         // write index
    logic [AW-1:0] rd_r;         // read index
    logic [AW:0]   cnt_r;        // words held
    logic          push;         // accepted write
    logic          pop;          // accepted read

    assign in_ready_o  = (cnt_r != (AW+1)'(D));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    // indices and fill count
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(D-1)) ? '0 : AW'(wr_r + 1'b1);
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(D-1)) ? '0 : AW'(rd_r + 1'b1);
            end
            if (push && !pop) begin
                cnt_r <= (AW+1)'(cnt_r + 1'b1);
            end else if (pop && !push) begin
                cnt_r <= (AW+1)'(cnt_r - 1'b1);
            end
        end
    end

endmodule

`default_nettype wire

// ===== design/dsic_pkg.sv
// Purpose: types of the serial input and clear front end
// Assumes: dsic_defines.svh sits beside this file
// Notes:   numbers live in the defines header
`include "dsic_defines.svh"

package dsic_pkg;

    // clear code selection
    typedef enum logic [1:0] {
        DSIC_CLR_ZERO = 2'h0,
        DSIC_CLR_MID  = 2'h1,
        DSIC_CLR_FULL = 2'h2
    } dsic_clrsel_e;

    // one converter code
    typedef logic [`DSIC_CODE_W-1:0] dsic_code_t;

    // one received serial word, msb first
    typedef struct packed {
        logic [3:0] spare;       // bits 31:28, ignored
        logic [3:0] cmd;         // command code
        logic [3:0] chan;        // channel, low three bits used
        dsic_code_t data;        // payload
        logic [3:0] tail;        // bits 3:0, ignored
    } dsic_word_s;

endpackage

// ===== design/dsic_top.sv
// Purpose: serial word receive, input/converter registers and clear
// Assumes: serial clock is its own domain; pins are asynchronous
// Notes:   words cross by toggle into the system clock domain
`timescale 1ns/1ns
`default_nettype none
`include "dsic_defines.svh"

module dsic_top
    import dsic_pkg::*;
#(
    parameter int CHAN_N = `DSIC_CHAN_N,
    parameter int DEPTH  = `DSIC_FIFO_DEPTH
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_i,
    input  wire logic                    sclk_i,
    input  wire logic                    frame_sel_n_i,
    input  wire logic                    serial_data_i,
    input  wire logic                    async_preset_input_n_i,
    input  wire logic                    output_update_strobe_n_i,
    output var  dsic_code_t [CHAN_N-1:0] conv_code_o,
    output var  logic                    reference_pin_o,
    output var  logic                    reference_pin_oe_o,
    output var  logic                    word_lost_o
);

    ////////////////////////////////////////////////////////////////////
    // helpers
    ////////////////////////////////////////////////////////////////////

    // clear selection to converter code
    function automatic dsic_code_t scale_code(input dsic_clrsel_e sel);
        dsic_code_t code;
        case (sel)
            DSIC_CLR_ZERO: code = `DSIC_ZERO_CODE;
            DSIC_CLR_MID:  code = `DSIC_MID_CODE;
            DSIC_CLR_FULL: code = `DSIC_FULL_CODE;
            default:       code = `DSIC_ZERO_CODE;
        endcase
        return code;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // link domain: serial clock
    ////////////////////////////////////////////////////////////////////

    logic [`DSIC_WORD_W-2:0] shift_r;      // bits gathered so far
    logic [5:0]              bit_cnt_r = '0; // falling edges in frame
    logic [`DSIC_WORD_W-1:0] hold_r = '0;  // last complete word
    logic                    tog_r  = 1'b0; // flips per complete word

    // edge count, cleared whenever frame select is high
    always_ff @(negedge sclk_i or posedge frame_sel_n_i) begin
        if (frame_sel_n_i) begin
            bit_cnt_r <= 6'h00;
        end else if (bit_cnt_r != `DSIC_FRAME_BITS) begin
            bit_cnt_r <= 6'(bit_cnt_r + 1'b1);
        end
    end

    // shift in on falling edge while frame open
    always_ff @(negedge sclk_i) begin
        if (!frame_sel_n_i && bit_cnt_r != `DSIC_FRAME_BITS) begin
            shift_r <= {shift_r[`DSIC_WORD_W-3:0], serial_data_i};
        end
    end

    // publish word on the 32nd edge only
    always_ff @(negedge sclk_i) begin
        if (!frame_sel_n_i &&
            bit_cnt_r == 6'(`DSIC_FRAME_BITS - 1'b1)) begin
            hold_r <= {shift_r, serial_data_i};
            tog_r  <= ~tog_r;
        end
    end

    // sampled bit lands in shift register
    chk_edge_sample: assert property (
        @(negedge sclk_i) disable iff (frame_sel_n_i)
        (bit_cnt_r < 6'h1F) |=> (shift_r[0] == $past(serial_data_i)))
        else $error("serial bit not taken on falling edge");

    // toggle only moves on the final edge
    chk_frame_abort: assert property (
        @(negedge sclk_i) disable iff (frame_sel_n_i)
        (bit_cnt_r != 6'h1F) |=> $stable(tog_r))
        else $error("word published before 32 edges");

    // final edge publishes the word
    chk_frame_done: assert property (
        @(negedge sclk_i) disable iff (frame_sel_n_i)
        (bit_cnt_r == 6'h1F) |=> (tog_r != $past(tog_r)))
        else $error("complete frame not published");

    ////////////////////////////////////////////////////////////////////
    // crossings into system clock
    ////////////////////////////////////////////////////////////////////

    logic tog_s1_r;      // toggle sync, first stage
    logic tog_s2_r;      // toggle sync, second stage
    logic tog_seen_r;    // last toggle acted on
    logic pre_s1_r;      // clear pin sync, first stage
    logic pre_s2_r;      // clear pin sync, second stage
    logic pre_d_r;       // clear level, previous cycle
    logic upd_s1_r;      // load strobe sync, first stage
    logic upd_s2_r;      // load strobe sync, second stage
    logic word_stb;      // new word arrived
    logic clr_fall;      // clear pin fell
    logic clr_low;       // clear held low

    // two-stage synchronisers
    always_ff @(posedge clk_sys_i) begin
        tog_s1_r <= tog_r;
        tog_s2_r <= tog_s1_r;
        pre_s1_r <= async_preset_input_n_i;
        pre_s2_r <= pre_s1_r;
        upd_s1_r <= output_update_strobe_n_i;
        upd_s2_r <= upd_s1_r;
    end

    // edge memory; reset takes current toggle level, clear level forced high
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tog_seen_r <= tog_s2_r;
            pre_d_r    <= 1'b1;
        end else begin
            tog_seen_r <= tog_s2_r;
            pre_d_r    <= pre_s2_r;
        end
    end

    assign word_stb = (tog_s2_r != tog_seen_r) && !reset_i;
    assign clr_fall = pre_d_r && !pre_s2_r && !reset_i;
    assign clr_low  = !pre_s2_r;

    ////////////////////////////////////////////////////////////////////
    // word buffer
    ////////////////////////////////////////////////////////////////////

    logic                    fifo_in_ready;  // room in buffer
    logic                    fifo_out_valid; // word waiting
    logic                    fifo_pop;       // word consumed
    logic [`DSIC_WORD_W-1:0] fifo_out;       // head word
    dsic_word_s              cmd;            // head word fields

    // hold words while clear is low
    assign fifo_pop = fifo_out_valid && !clr_low;
    assign cmd      = dsic_word_s'(fifo_out);

    dsic_fifo #(
        .W (`DSIC_WORD_W),
        .D (DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_valid_i  (word_stb),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (hold_r),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!clr_low),
        .out_data_o  (fifo_out)
    );

    // sticky flag: word arrived with buffer full
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            word_lost_o <= 1'b0;
        end else if (word_stb && !fifo_in_ready) begin
            word_lost_o <= 1'b1;
        end
    end

    // arriving word is buffered
    chk_word_push: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        (word_stb && fifo_in_ready) |=> fifo_out_valid)
        else $error("received word not buffered");

    ////////////////////////////////////////////////////////////////////
    // configuration
    ////////////////////////////////////////////////////////////////////

    dsic_clrsel_e clr_sel_r;    // selected clear level
    logic         ref_int_r;    // internal reference chosen

    // clear code and reference selection
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            clr_sel_r <= dsic_clrsel_e'(`DSIC_CLRSEL_RESET);
            ref_int_r <= 1'b0;
        end else if (fifo_pop) begin
            if (cmd.cmd == `DSIC_CMD_CLRCODE) begin
                clr_sel_r <= dsic_clrsel_e'(cmd.data[1:0]);
            end else if (cmd.cmd == `DSIC_CMD_REFSEL) begin
                ref_int_r <= cmd.data[0];
            end
        end
    end

    // reference pin drives only for internal reference
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reference_pin_oe_o <= 1'b0;
            reference_pin_o    <= 1'b0;
        end else begin
            reference_pin_oe_o <= ref_int_r;
            reference_pin_o    <= ref_int_r;
        end
    end

    chk_reset_code: assert property (
        @(posedge clk_sys_i)
        reset_i |=> (clr_sel_r == DSIC_CLR_ZERO) && !reference_pin_oe_o)
        else $error("reset clear code or reference mode wrong");

    chk_ref_follow: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !ref_int_r |=> !reference_pin_oe_o)
        else $error("reference pin driven without internal choice");

    ////////////////////////////////////////////////////////////////////
    // channel registers
    ////////////////////////////////////////////////////////////////////

    dsic_code_t [CHAN_N-1:0] input_r;   // input registers
    logic [CHAN_N-1:0]       pend_r;    // input newer than converter
    logic                    upd_ok;    // strobe low, clear high

    assign upd_ok = !upd_s2_r && !clr_low;

    for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_chan
        logic sel_ch;   // head word targets this channel
        assign sel_ch = fifo_pop && (cmd.cmd == `DSIC_CMD_WRITE) &&
                        (cmd.chan[2:0] == 3'(ch));

        // input register and pending flag
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
                input_r[ch] <= `DSIC_CODE_RESET;
                pend_r[ch]  <= 1'b0;
            end else if (clr_fall) begin
                input_r[ch] <= scale_code(clr_sel_r);
                pend_r[ch]  <= 1'b0;
            end else if (sel_ch) begin
                input_r[ch] <= cmd.data;
                pend_r[ch]  <= 1'b1; // new data wins over copy
            end else if (upd_ok) begin
                pend_r[ch]  <= 1'b0;
            end
        end

        // converter register, straight to output
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
                conv_code_o[ch] <= `DSIC_CODE_RESET;
            end else if (clr_fall) begin
                conv_code_o[ch] <= scale_code(clr_sel_r);
            end else if (upd_ok && pend_r[ch]) begin
                conv_code_o[ch] <= input_r[ch];
            end
        end
    end

    // clear loads the selected code into converter
    chk_clear_load: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        clr_fall |=> (conv_code_o[0] == scale_code($past(clr_sel_r))) &&
                     (input_r[0] == conv_code_o[0]))
        else $error("clear did not load clear code");

    // midscale maps to exact code
    chk_scale_mid: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        (clr_fall && clr_sel_r == DSIC_CLR_MID) |=>
            (conv_code_o[CHAN_N-1] == 16'h8000))
        else $error("midscale clear code wrong");

    // strobe has no effect while clear low
    chk_strobe_block: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        (clr_low && !clr_fall && !upd_s2_r) |=> $stable(conv_code_o))
        else $error("converter changed while clear low");

    // strobe copies pending input
    chk_strobe_copy: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        (upd_ok && pend_r[0] && !clr_fall) |=>
            (conv_code_o[0] == $past(input_r[0])))
        else $error("strobe did not update converter");

endmodule

`default_nettype wire

// ===== dv/dsic_host_model.sv
// Purpose: host side of the three-wire serial link
// Assumes: called by the bench through its send task
// Notes:   link clock stands still high between frames
`timescale 1ns/1ns
`default_nettype none

module dsic_host_model (
    output var logic sclk_o,
    output var logic frame_sel_n_o,
    output var logic serial_data_o
);
    // half period of the link clock, held at the 50 MHz ceiling
    localparam int HALF_NS = 10;

    ////////////////////////////////////////////////////////////////////
    // idle levels of the link
    initial begin
        sclk_o        = 1'b1;
        frame_sel_n_o = 1'b1;
        serial_data_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // one frame of nbits bits, msb first; fewer than 32 aborts it
    task automatic send(input logic [31:0] word, input int nbits);
        frame_sel_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            // bit set half a period before the sampling edge
            serial_data_o = word[31-i];
            #HALF_NS sclk_o = 1'b0;
            #HALF_NS sclk_o = 1'b1;
        end
        // released data line shows no stale value
        serial_data_o = ~serial_data_o;
        #HALF_NS frame_sel_n_o = 1'b1;
        #(2*HALF_NS);
    endtask
endmodule

`default_nettype wire

// ===== dv/dsic_top_test.sv
// Purpose: self-checking bench of the serial input and clear block
// Assumes: host model drives the link; bench drives the pins
// Notes:   a reference model in functions predicts the channel and configuration registers
`timescale 1ns/1ns
`default_nettype none

module dsic_top_test;
    import dsic_pkg::*;

    logic             clk_sys_i = 1'b0; // system clock
    logic             reset_i   = 1'b1; // sync reset
    logic             clr_n     = 1'b1; // clear pin
    logic             upd_n     = 1'b1; // load strobe pin
    wire logic        sclk;             // link clock
    wire logic        fsel_n;           // frame select
    wire logic        sdata;            // serial data
    dsic_code_t [7:0] conv_code;        // converter registers
    logic             ref_o;            // reference drive value
    logic             ref_oe;           // reference drive enable
    logic             lost;             // sticky overflow
    int               n_errors  = 0;    // mismatches
    int               cmp_count = 0;    // comparisons
    int               cycles    = 0;    // timeout counter
    dsic_code_t       in_m [8];         // expected input registers
    dsic_code_t       conv_m [8];       // expected converter regs
    logic [7:0]       pend_m;           // expected pending flags
    logic [1:0]       sel_m;            // expected clear select
    logic             oe_m;             // expected reference enable
    logic             lost_m;           // expected overflow flag
    logic [31:0]      w;                // scratch word

    dsic_host_model u_dsic_host_model (
        .sclk_o        (sclk),
        .frame_sel_n_o (fsel_n),
        .serial_data_o (sdata)
    );

    dsic_top #(.CHAN_N(8), .DEPTH(16)) u_dsic_top (
        .clk_sys_i                (clk_sys_i),
        .reset_i                  (reset_i),
        .sclk_i                   (sclk),
        .frame_sel_n_i            (fsel_n),
        .serial_data_i            (sdata),
        .async_preset_input_n_i   (clr_n),
        .output_update_strobe_n_i (upd_n),
        .conv_code_o              (conv_code),
        .reference_pin_o          (ref_o),
        .reference_pin_oe_o       (ref_oe),
        .word_lost_o              (lost)
    );

    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #5 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // reference model
    function automatic dsic_code_t level(input logic [1:0] s);
        return (s == 2'h1) ? 16'h8000 : (s == 2'h2) ? 16'hFFFF : 16'h0000;
    endfunction

    function automatic logic [31:0] mk(input logic [3:0] c,
                                       input logic [3:0] ch,
                                       input logic [15:0] d);
        return {4'h0, c, ch, d, 4'h0};
    endfunction

    function automatic void copy();
        for (int i = 0; i < 8; i++) begin
            if (pend_m[i]) conv_m[i] = in_m[i];
        end
        pend_m = 8'h00;
    endfunction

    function automatic void apply(input logic [31:0] x);
        dsic_word_s s;
        s = x;
        case (s.cmd)
            4'h0: begin
                in_m[s.chan[2:0]]   = s.data;
                pend_m[s.chan[2:0]] = 1'b1;
            end
            4'h1: sel_m = s.data[1:0];
            4'h2: oe_m = s.data[0];
            default: ;
        endcase
        if (!upd_n) copy();
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin and link tasks
    task automatic send(input logic [31:0] x, input int nbits,
                        input bit use_it);
        u_dsic_host_model.send(x, nbits);
        repeat (10) @(posedge clk_sys_i);
        #1;
        if (use_it) apply(x);
    endtask

    task automatic strobe();
        @(posedge clk_sys_i);
        #1 upd_n = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 upd_n = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        #1;
        if (clr_n) copy();
    endtask

    task automatic clear_pin(input logic v);
        @(posedge clk_sys_i);
        #1 clr_n = v;
        repeat (6) @(posedge clk_sys_i);
        #1;
        if (!v) begin
            for (int i = 0; i < 8; i++) begin
                in_m[i]   = level(sel_m);
                conv_m[i] = level(sel_m);
            end
            pend_m = 8'h00;
        end
    endtask

    task automatic expect_all();
        for (int i = 0; i < 8; i++) begin
            check($sformatf("conv%0d", i), conv_code[i], conv_m[i]);
        end
        check("ref_oe", {15'h0, ref_oe}, {15'h0, oe_m});
        check("ref_o", {15'h0, ref_o}, {15'h0, oe_m});
        check("word_lost", {15'h0, lost}, {15'h0, lost_m});
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'hB1713B86));
        sel_m  = 2'h0;
        oe_m   = 1'b0;
        lost_m = 1'b0;
        pend_m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            in_m[i]   = 16'h0000;
            conv_m[i] = 16'h0000;
        end
        repeat (4) @(posedge clk_sys_i);
        #1 reset_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        expect_all();
        // random writes wait in input registers until the strobe
        for (int i = 0; i < 8; i++) begin
            send(mk(4'h0, 4'(i), 16'($urandom)), 32, 1'b1);
        end
        expect_all();
        strobe();
        expect_all();
        // frame cut one bit short changes nothing
        send(mk(4'h0, 4'h0, ~in_m[0]), 31, 1'b0);
        strobe();
        expect_all();
        // unconfigured clear, then every select value
        send(mk(4'h0, 4'h5, 16'($urandom)), 32, 1'b1);
        clear_pin(1'b0);
        expect_all();
        clear_pin(1'b1);
        for (int s = 3; s >= 0; s--) begin
            send(mk(4'h1, 4'h0, 16'(s)), 32, 1'b1);
            clear_pin(1'b0);
            strobe();
            expect_all();
            clear_pin(1'b1);
            expect_all();
        end
        // reference pin driven only with internal reference
        send(mk(4'h2, 4'h0, 16'h0001), 32, 1'b1);
        expect_all();
        send(mk(4'h2, 4'h0, 16'h0000), 32, 1'b1);
        expect_all();
        // strobe tied low: each write reaches its converter
        upd_n = 1'b0;
        send(mk(4'h0, 4'h7, 16'hFFFE), 32, 1'b1);
        send(mk(4'h0, 4'h0, 16'($urandom)), 32, 1'b1);
        expect_all();
        @(posedge clk_sys_i);
        #1 upd_n = 1'b1;
        // clear low stalls the buffer: fill past 16, strobe ignored
        clear_pin(1'b0);
        for (int i = 0; i < 17; i++) begin
            w = mk(4'h0, 4'(i % 8), 16'($urandom));
            u_dsic_host_model.send(w, 32);
            // the first 16 wait in the buffer, the last is dropped
            if (i < 16) apply(w);
        end
        repeat (10) @(posedge clk_sys_i);
        strobe();
        lost_m = 1'b1;
        expect_all();
        clear_pin(1'b1);
        repeat (40) @(posedge clk_sys_i);
        expect_all();
        // drained words reach the converters only with the strobe
        strobe();
        expect_all();
        end_of_test();
    end
endmodule

`default_nettype wire
